/* File: rtl/facap_core.sv */
// fault alert line and parametric capture with flash store and restore control
// What the document requires of this block and the host
// RULE1 - pull the alert line low while any alert-enabled fault is pending
// RULE2 - host answers a low alert line with an alert response transfer
// RULE3 - host then talks to the alerting device; its actions are system defined
// RULE4 - line stays low while faults remain; host repeats alert response transfers
// RULE5 - capture works only while configuration bit 1 is one
// RULE6 - captured data returned as one 22 byte block read, even while regulating
// RULE7 - control value 1 copies flash capture image into RAM
// RULE8 - control value 2 stores capture to flash, only while output disabled
// RULE9 - a fault with shutdown response stores the capture to flash automatically; the code stores only if the flash engine is idle when the fault rises
// RULE10 - a fault with retry response never triggers the automatic store
// RULE11 - a flash store takes 700 to 1400 microseconds
// RULE12 - host recovers lost data by writing 1 then reading the capture
// RULE13 - at start-up load stored configuration when flash holds it
// RULE14 - default and user stores; restores limited to granted security level
// RULE15 - under the default store, default restore allowed, factory restore refused
// RULE16 - release alert once serviced and no alerting fault remains
`timescale 1ns/1ps
`default_nettype none
module facap_core
  import facap_pkg::*;
#(
  parameter int unsigned NFLT      = 8,
  parameter int unsigned STORE_CYC = facap_pkg::STORE_MIN_CYC,
  parameter int unsigned BLK_CYC   = facap_pkg::STORE_MAX_CYC
) (
  // clock and reset
  input  wire logic                       ref_clk_i,
  input  wire logic                       rst_b_i,
  // fault sources and their configuration
  input  wire logic [NFLT-1:0]            fault_i,
  input  wire logic [NFLT-1:0]            fault_alert_en_i,
  input  wire logic [NFLT-1:0]            fault_shutdown_i,
  input  wire logic [MISC_W-1:0]          misc_cfg_i,
  input  wire logic                       out_enabled_i,
  // alert service from the SMBus engine
  input  wire logic                       ara_done_i,
  input  wire logic                       fault_clear_i,
  // fault alert line, open drain
  input  wire logic                       fault_alert_line_i,
  output logic                            fault_alert_line_o,
  output logic                            fault_alert_line_oe_o,
  // live parameters and capture read
  input  wire logic [CAP_BYTES*8-1:0]     live_i,
  input  wire facap_pkg::facap_rd_s       rd_i,
  output logic [7:0]                      rd_data_o,
  output logic                            rd_valid_o,
  // capture control command and store mode
  input  wire logic                       ctl_wr_i,
  input  wire logic [7:0]                 ctl_data_i,
  input  wire logic                       blk_layout_i,
  output logic                            busy_o,
  output logic                            refused_o,
  // non-volatile configuration
  input  wire logic                       nvm_valid_i,
  input  wire logic                       default_store_i,
  input  wire facap_pkg::facap_restore_s  restore_i,
  output logic                            cfg_load_o,
  output logic [1:0]                      restore_o
);
  import facap_pkg::*;

  logic [NFLT-1:0]          pend_reg, pend_next;
  logic                     served_reg, served_next;
  logic                     line_reg, line_next;
  logic [7:0]               ram_reg [CAP_BYTES];
  logic [7:0]               flash_reg [CAP_BYTES];
  logic [7:0]               rd_data_reg, rd_data_next;
  logic                     rd_valid_reg, rd_valid_next;
  facap_state_e             st_reg, st_next;
  logic [TMR_W-1:0]         tmr_reg, tmr_next;
  logic                     busy_reg, busy_next;
  logic                     ref_reg, ref_next;
  logic                     cfg_reg, cfg_next;
  logic [1:0]               rest_reg, rest_next;
  logic [NFLT-1:0]          fault_d_reg;
  logic                     line_s1_reg;
  logic                     line_s2_reg;
  logic                     held_reg, held_next;
  logic                     cap_en;
  logic                     auto_st;
  logic                     do_snap;

  assign cap_en = misc_cfg_i[MISC_CAP_BIT]; // [RULE5]
  // only faults whose response is shutdown start the store [RULE9] [RULE10]
  assign auto_st = cap_en && |(fault_i & ~fault_d_reg & fault_shutdown_i);
  // a loaded flash image is held for reads until a shutdown fault replaces it or capture is disabled [RULE7]
  assign do_snap = cap_en && st_reg == FACAP_IDLE && (!held_reg || auto_st);

  // alert pending bits: any present alert-enabled fault sets, clear after service drops it
  always_comb
  begin
    pend_next   = pend_reg;
    served_next = served_reg;
    if (fault_clear_i)
      pend_next = '0;
    pend_next = pend_next | (fault_i & fault_alert_en_i); // set wins [RULE1]
    if (ara_done_i && line_reg)
      served_next = 1'b1; // [RULE4]
    if (pend_next == '0)
      served_next = 1'b0;
    line_next = |pend_next; // stays low until all pending cleared [RULE4] [RULE16]
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      pend_reg    <= '0;
      served_reg  <= 1'b0;
      line_reg    <= 1'b0;
      fault_d_reg <= '0;
      line_s1_reg <= 1'b1;
      line_s2_reg <= 1'b1;
    end
    else
    begin
      pend_reg    <= pend_next;
      served_reg  <= served_next;
      line_reg    <= line_next;
      fault_d_reg <= fault_i;
      // shared line from the pin: two flops, only the second one is read
      line_s1_reg <= fault_alert_line_i;
      line_s2_reg <= line_s1_reg;
    end
  end

  // capture read: 22 bytes by index, allowed while regulating [RULE6]
  always_comb
  begin
    rd_valid_next = rd_i.req && cap_en && rd_i.idx < CAP_IDX_W'(CAP_BYTES);
    rd_data_next  = rd_valid_next ? ram_reg[rd_i.idx] : 8'h00;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      rd_data_reg  <= 8'h00;
      rd_valid_reg <= 1'b0;
    end
    else
    begin
      rd_data_reg  <= rd_data_next;
      rd_valid_reg <= rd_valid_next;
    end
  end

  // capture RAM and flash image, one entry per byte
  for (genvar g = 0; g < CAP_BYTES; g++)
  begin : g_cap
    always_ff @(posedge ref_clk_i)
    begin
      if (!rst_b_i)
        ram_reg[g] <= 8'h00;
      else if (st_reg == FACAP_LOAD)
        ram_reg[g] <= flash_reg[g]; // [RULE7]
      else if (do_snap)
        ram_reg[g] <= live_i[g*8 +: 8];
    end
    always_ff @(posedge ref_clk_i)
    begin
      if (st_reg == FACAP_STORE)
        flash_reg[g] <= ram_reg[g]; // [RULE8] [RULE9]
    end
  end

  // flash engine: init load, command decode, timed store
  always_comb
  begin
    st_next   = st_reg;
    tmr_next  = tmr_reg;
    busy_next = busy_reg;
    ref_next  = 1'b0;
    cfg_next  = 1'b0;
    rest_next = 2'h0;
    held_next = held_reg && cap_en && !(auto_st && st_reg == FACAP_IDLE); // [RULE7]
    case (st_reg)
      FACAP_INIT:
      begin
        cfg_next = nvm_valid_i; // [RULE13]
        st_next  = FACAP_IDLE;
      end
      FACAP_IDLE:
      begin
        busy_next = 1'b0;
        if (auto_st)
          st_next = FACAP_STORE; // [RULE9]
        else if (ctl_wr_i && ctl_data_i == CTL_LOAD && cap_en)
          st_next = FACAP_LOAD; // [RULE7]
        else if (ctl_wr_i && ctl_data_i == CTL_STORE && cap_en && !out_enabled_i)
          st_next = FACAP_STORE; // [RULE8]
        else if (ctl_wr_i)
          ref_next = 1'b1;
        if (st_next != FACAP_IDLE)
          busy_next = 1'b1;
      end
      FACAP_LOAD:
      begin
        held_next = 1'b1; // keep the loaded image for capture reads [RULE7]
        st_next   = FACAP_IDLE;
      end
      FACAP_STORE:
      begin
        tmr_next = TMR_W'(blk_layout_i ? BLK_CYC - 1 : STORE_CYC - 1); // [RULE11]
        st_next  = FACAP_WAIT;
      end
      FACAP_WAIT:
      begin
        tmr_next = tmr_reg - TMR_W'(1);
        if (tmr_reg == '0)
          st_next = FACAP_IDLE;
      end
      default:
        st_next = FACAP_IDLE;
    endcase
    // restores limited to the granted level; factory refused on default store
    if (restore_i.req)
    begin
      if (restore_i.level < restore_i.target ||
          (default_store_i && restore_i.target == RST_FACTORY)) // [RULE14] [RULE15]
        ref_next = 1'b1;
      else
        rest_next = restore_i.target;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      st_reg   <= FACAP_INIT;
      tmr_reg  <= '0;
      busy_reg <= 1'b1;
      ref_reg  <= 1'b0;
      cfg_reg  <= 1'b0;
      rest_reg <= 2'h0;
      held_reg <= 1'b0;
    end
    else
    begin
      st_reg   <= st_next;
      tmr_reg  <= tmr_next;
      busy_reg <= busy_next;
      ref_reg  <= ref_next;
      cfg_reg  <= cfg_next;
      rest_reg <= rest_next;
      held_reg <= held_next;
    end
  end

  // outputs from flops, line data tied low; oe low drives the line low [RULE1]
  assign fault_alert_line_o    = 1'b0;
  assign fault_alert_line_oe_o = ~line_reg;
  assign rd_data_o             = rd_data_reg;
  assign rd_valid_o            = rd_valid_reg;
  assign busy_o                = busy_reg;
  assign refused_o             = ref_reg;
  assign cfg_load_o            = cfg_reg;
  assign restore_o             = rest_reg;

  // checks
  AST_ALERT_SET: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [RULE1]
    |(fault_i & fault_alert_en_i) |=> !fault_alert_line_oe_o)
    else $error("alert line not pulled after alert fault");
  AST_ALERT_HOLD: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [RULE4]
    (pend_reg != '0 && !fault_clear_i) |=> line_reg)
    else $error("alert released with fault pending");
  AST_ALERT_REL: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [RULE16]
    (fault_clear_i && !(|(fault_i & fault_alert_en_i))) |=> fault_alert_line_oe_o)
    else $error("alert not released after clear");
  AST_LINE_SEEN: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [RULE1]
    line_reg |=> ##1 !line_s2_reg)
    else $error("driven alert line not seen low");
  AST_RD_GATE: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [RULE5]
    !cap_en |=> !rd_valid_o)
    else $error("capture read with capture disabled");
  AST_RD_RANGE: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [RULE6]
    (rd_i.req && cap_en && rd_i.idx < CAP_IDX_W'(CAP_BYTES)) |=> rd_valid_o)
    else $error("capture byte not returned");
  AST_LOAD: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [RULE7]
    (st_reg == FACAP_IDLE && ctl_wr_i && ctl_data_i == CTL_LOAD && cap_en && !auto_st)
    |=> st_reg == FACAP_LOAD ##1 ram_reg[0] == $past(flash_reg[0]))
    else $error("load did not copy flash");
  AST_STORE_EN: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [RULE8]
    (st_reg == FACAP_IDLE && out_enabled_i && !auto_st && ctl_wr_i && ctl_data_i == CTL_STORE)
    |=> st_reg != FACAP_STORE)
    else $error("store accepted while output enabled");
  AST_AUTO: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [RULE9]
    (st_reg == FACAP_IDLE && auto_st) |=> st_reg == FACAP_STORE)
    else $error("shutdown fault did not store");
  AST_RETRY: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [RULE10]
    (st_reg == FACAP_IDLE && !auto_st && !ctl_wr_i) |=> st_reg != FACAP_STORE)
    else $error("store without shutdown fault");
  AST_TIME: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [RULE11]
    (st_reg == FACAP_WAIT && tmr_reg != '0) |=> st_reg == FACAP_WAIT)
    else $error("store ended early");
  AST_FACTORY: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [RULE15]
    (restore_i.req && default_store_i && restore_i.target == RST_FACTORY)
    |=> refused_o && restore_o == 2'h0)
    else $error("factory restore allowed");
  AST_LEVEL: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [RULE14]
    (restore_i.req && restore_i.level < restore_i.target) |=> refused_o && restore_o == 2'h0)
    else $error("restore above granted level");
  AST_INIT: assert property (@(posedge ref_clk_i) // [RULE13]
    (!rst_b_i ##1 rst_b_i && nvm_valid_i) |=> cfg_load_o)
    else $error("stored configuration not loaded");
  COV_ALERT: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    !fault_alert_line_oe_o ##[1:20] fault_alert_line_oe_o);
  COV_AUTO: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    st_reg == FACAP_STORE);
  COV_LOAD: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    st_reg == FACAP_LOAD ##[1:10] rd_valid_o);
  COV_SERVED: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    served_reg ##1 !served_reg);
endmodule
`default_nettype wire

/* File: rtl/facap_pkg.sv */
// package: constants and types for the fault alert and parameter capture block
package facap_pkg;
  // capture image size in bytes
  localparam int unsigned CAP_BYTES      = 22;
  localparam int unsigned CAP_IDX_W      = 5;
  // configuration bit that enables capture
  localparam int unsigned MISC_CAP_BIT   = 1;
  localparam int unsigned MISC_W         = 8;
  // capture control command values
  localparam logic [7:0]  CTL_LOAD       = 8'h01;
  localparam logic [7:0]  CTL_STORE      = 8'h02;
  // clock rate and flash store time
  localparam int unsigned CLK_MHZ        = 200;
  localparam int unsigned STORE_MIN_US   = 700;
  localparam int unsigned STORE_MAX_US   = 1400;
  localparam int unsigned STORE_MIN_CYC  = STORE_MIN_US * CLK_MHZ;
  localparam int unsigned STORE_MAX_CYC  = STORE_MAX_US * CLK_MHZ;
  localparam int unsigned TMR_W          = 20;
  // restore targets and security levels
  localparam logic [1:0]  RST_DEFAULT    = 2'h1;
  localparam logic [1:0]  RST_FACTORY    = 2'h2;
  localparam logic [1:0]  RST_USER       = 2'h3;

  // flash engine states
  typedef enum logic [4:0] {
    FACAP_IDLE  = 5'h01,
    FACAP_INIT  = 5'h02,
    FACAP_LOAD  = 5'h04,
    FACAP_STORE = 5'h08,
    FACAP_WAIT  = 5'h10
  } facap_state_e;

  // byte read request from the SMBus engine
  typedef struct packed {
    logic                 req;
    logic [CAP_IDX_W-1:0] idx;
  } facap_rd_s;

  // restore request
  typedef struct packed {
    logic       req;
    logic [1:0] target;
    logic [1:0] level;
  } facap_restore_s;
endpackage

/* File: testbench/facap_core_bench.sv */
// self-checking bench for the fault alert and capture block
`timescale 1ns/1ps
`default_nettype none
module facap_core_bench;
  import facap_pkg::*;
  localparam int SC = 20;
  localparam int BC = 40;
  logic clk, rst_b, oen, ara, clr, cw, blk, nvm, ds, svc, line_o, oe, rdv, busy, refd, cfgl;
  logic [7:0] flt, aen, sdn, misc, cd, rdd;
  logic [175:0] live;
  logic [1:0] rso, rs_last;
  facap_rd_s rd;
  facap_restore_s rq;
  wire logic line_w;
  int err_count, total_checks, busy_n, ref_n, cfg_n, ara_n, cyc, rs_n;
  // open drain wire with pull-up
  assign line_w = oe ? 1'b1 : line_o;
  facap_core #(.STORE_CYC(SC), .BLK_CYC(BC)) facap_core_inst (
    .ref_clk_i(clk), .rst_b_i(rst_b), .fault_i(flt), .fault_alert_en_i(aen),
    .fault_shutdown_i(sdn), .misc_cfg_i(misc), .out_enabled_i(oen), .ara_done_i(ara),
    .fault_clear_i(clr), .fault_alert_line_i(line_w), .fault_alert_line_o(line_o),
    .fault_alert_line_oe_o(oe), .live_i(live), .rd_i(rd), .rd_data_o(rdd),
    .rd_valid_o(rdv), .ctl_wr_i(cw), .ctl_data_i(cd), .blk_layout_i(blk),
    .busy_o(busy), .refused_o(refd), .nvm_valid_i(nvm), .default_store_i(ds),
    .restore_i(rq), .cfg_load_o(cfgl), .restore_o(rso));
  facap_host_model facap_host_model_inst (
    .ref_clk_i(clk), .svc_en_i(svc), .fault_alert_line_i(line_w),
    .ara_done_o(ara), .fault_clear_o(clr));
  always #2.5 clk = ~clk;
  // event counters and timeout
  always @(posedge clk)
  begin
    cyc++;
    if (busy === 1'b1) busy_n++;
    if (refd === 1'b1) ref_n++;
    if (cfgl === 1'b1) cfg_n++;
    if (ara === 1'b1) ara_n++;
    if (rso !== 2'h0)
    begin
      rs_last <= rso;
      rs_n++;
    end
    if (cyc == 20000)
    begin
      err_count++;
      test_done();
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t %s got %0h exp %0h", $time, msg, got, exp);
    end
  endtask
  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task ctl(input logic [7:0] v);
    cw = 1'b1;
    cd = v;
    step(1);
    cw = 1'b0;
  endtask
  task t_reset(input logic nv);
    int c;
    nvm = nv;
    rst_b = 1'b0;
    step(5);
    chk(line_w, 1'b1, "line in reset");
    c = cfg_n;
    rst_b = 1'b1;
    step(5);
    chk(cfg_n - c, nv, "config load");
    $display("test reset done");
  endtask
  task t_alert();
    int n;
    aen = 8'h01;
    flt = 8'h02;
    step(4);
    chk(line_w, 1'b1, "unmasked only");
    flt = 8'h03;
    step(2);
    chk(line_w, 1'b0, "alert low");
    chk(line_o, 1'b0, "drive level");
    n = ara_n;
    svc = 1'b1;
    step(20);
    chk(line_w, 1'b0, "held while pending");
    chk((ara_n - n) >= 2, 1'b1, "repeated service");
    flt = 8'h00;
    step(12);
    chk(line_w, 1'b1, "released");
    svc = 1'b0;
    aen = 8'h00;
    $display("test alert done");
  endtask
  task t_read();
    int k;
    for (k = 0; k < 22; k++) live[8*k +: 8] = 8'hA0 + k[7:0];
    oen = 1'b1;
    misc = 8'h02;
    step(3);
    rd.req = 1'b1;
    rd.idx = 5'h00;
    for (k = 0; k < 22; k++)
    begin
      step(1);
      chk(rdv, 1'b1, "read valid");
      chk(rdd, 8'hA0 + k[7:0], "read byte");
      rd.idx = k[4:0] + 5'h01;
    end
    step(1);
    chk(rdv, 1'b0, "index past block");
    rd.req = 1'b0;
    misc = 8'h00;
    step(3);
    rd.req = 1'b1;
    rd.idx = 5'h00;
    step(1);
    rd.req = 1'b0;
    chk(rdv, 1'b0, "capture disabled");
    misc = 8'h02;
    $display("test read done");
  endtask
  task t_ctl();
    int b, r;
    oen = 1'b1;
    b = busy_n;
    r = ref_n;
    ctl(CTL_STORE);
    step(4);
    chk(ref_n - r, 1, "store while enabled");
    chk(busy_n - b, 0, "no store while enabled");
    oen = 1'b0;
    r = ref_n;
    ctl(8'h03);
    step(4);
    chk(ref_n - r, 1, "unknown value");
    b = busy_n;
    ctl(CTL_STORE);
    step(60);
    chk((busy_n - b >= SC) && (busy_n - b <= SC + 3), 1'b1, "short store");
    blk = 1'b1;
    b = busy_n;
    ctl(CTL_STORE);
    step(80);
    chk((busy_n - b >= BC) && (busy_n - b <= BC + 3), 1'b1, "long store");
    blk = 1'b0;
    b = busy_n;
    r = ref_n;
    live = {22{8'h55}};
    ctl(CTL_LOAD);
    step(6);
    chk(busy_n - b, 2, "load busy");
    chk(ref_n - r, 0, "load accepted");
    rd.req = 1'b1;
    rd.idx = 5'h03;
    step(1);
    rd.req = 1'b0;
    chk(rdd, 8'hA3, "flash image read back");
    $display("test control done");
  endtask
  task t_auto();
    int b;
    sdn = 8'h01;
    b = busy_n;
    flt = 8'h01;
    step(60);
    chk((busy_n - b >= SC) && (busy_n - b <= SC + 3), 1'b1, "auto store");
    flt = 8'h00;
    sdn = 8'h00;
    step(2);
    b = busy_n;
    flt = 8'h02;
    step(30);
    chk(busy_n - b, 0, "retry no store");
    flt = 8'h00;
    $display("test auto store done");
  endtask
  task t_restore();
    int d, t, l, r, g;
    logic ok;
    for (d = 0; d < 2; d++)
      for (t = 1; t < 4; t++)
        for (l = 0; l < 4; l++)
        begin
          ds = d[0];
          r = ref_n;
          g = rs_n;
          rq.req = 1'b1;
          rq.target = t[1:0];
          rq.level = l[1:0];
          step(1);
          rq.req = 1'b0;
          step(2);
          ok = (l >= t) && !((t == 2) && (d == 1));
          chk(rs_n - g, ok, "restore grant");
          chk(ref_n - r, !ok, "restore refusal");
          if (ok)
            chk(rs_last, t, "restore target");
        end
    $display("test restore done");
  endtask
  task test_done();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if ((err_count == 0) && (total_checks > 0))
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // main sequence
  initial
  begin
    clk = 1'b0;
    {rst_b, oen, cw, blk, nvm, ds, svc} = '0;
    {flt, aen, sdn, cd, live, rd, rq} = '0;
    misc = 8'h02;
    t_reset(1'b1);
    t_alert();
    t_read();
    t_ctl();
    t_auto();
    t_restore();
    t_reset(1'b0);
    test_done();
  end
endmodule
`default_nettype wire

/* File: testbench/facap_host_model.sv */
// host model: services a low fault alert line by alert response and fault clear
`timescale 1ns/1ps
`default_nettype none
module facap_host_model (
  // clock and service enable
  input  wire logic ref_clk_i,
  input  wire logic svc_en_i,
  // alert wire and service pulses
  input  wire logic fault_alert_line_i,
  output logic      ara_done_o,
  output logic      fault_clear_o
);
  // one service round per low line, repeated while it stays low
  initial
  begin
    ara_done_o    = 1'b0;
    fault_clear_o = 1'b0;
    forever
    begin
      @(posedge ref_clk_i);
      if (svc_en_i && (fault_alert_line_i === 1'b0))
      begin
        #1 ara_done_o = 1'b1;
        @(posedge ref_clk_i);
        #1 ara_done_o = 1'b0;
        fault_clear_o = 1'b1;
        @(posedge ref_clk_i);
        #1 fault_clear_o = 1'b0;
        repeat (2) @(posedge ref_clk_i);
      end
    end
  end
endmodule
`default_nettype wire
